//--- common/ctxq_regs.vh
// Purpose: Register map, field layout and timing constants of the CAN
//          transmit write queue.
// Assumes: APB slave, 32-bit data, one aligned word per register.
// Notes:   Included by the queue design file only.
`ifndef CTXQ_REGS_VH
`define CTXQ_REGS_VH

`define CTXQ_CTRL_OFS      8'h00
`define CTXQ_PERIOD_OFS    8'h04
`define CTXQ_DEPTH_OFS     8'h08
`define CTXQ_SIZE_OFS      8'h0C
`define CTXQ_KIND_OFS      8'h10
`define CTXQ_ID_OFS        8'h14
`define CTXQ_DLO_OFS       8'h18
`define CTXQ_DHI_OFS       8'h1C
`define CTXQ_LEN_OFS       8'h20
`define CTXQ_PUSH_OFS      8'h24
`define CTXQ_STAT_OFS      8'h28
`define CTXQ_IRQ_OFS       8'h2C
`define CTXQ_MASK_OFS      8'h30
`define CTXQ_LEVEL_OFS     8'h34

`define CTXQ_CTRL_START_BIT 0
`define CTXQ_CTRL_PER_BIT   1

`define CTXQ_KIND_DATA      8'h00
`define CTXQ_KIND_REMOTE    8'h01
`define CTXQ_KIND_LIN_RESP  8'h10
`define CTXQ_KIND_LIN_HDR   8'h11
`define CTXQ_KIND_LIN_FULL  8'h12

`define CTXQ_XTD_BIT        29
`define CTXQ_FRAME_SIZE     32'h0000_0018

`define CTXQ_EV_DONE_BIT    0
`define CTXQ_EV_OVF_BIT     1
`define CTXQ_EV_SIZE_BIT    2
`define CTXQ_EV_KIND_BIT    3

`define CTXQ_PERIOD_RST     32'h0000_0000
`define CTXQ_DEPTH_RST      8'h08

`endif

//--- design/ctxq_top.v
// Purpose: CAN transmit write queue: APB-fed FIFO of frame descriptors
//          drained to a CAN controller on demand or each period.
// Assumes: Controller reports done with ack only after won arbitration
//          and an acknowledge from another node.
// Notes:   Queue storage is an in-module array, depth a parameter.
`include "ctxq_regs.vh"

// Summary of operation
// - A push only stores the descriptor; the bus answers without waiting.
// - Write-complete rises when the queue is empty and the last frame went out, or on start with an empty queue.
// - Write-complete stays set until the next accepted push clears it.
// - Starting communication sets write-complete before any push.
// - In periodic mode one item is taken and sent at each period boundary.
// - In periodic mode an empty queue resends the previous payload.
// - A push into a full queue raises write overflow and is dropped.
// - With depth zero a push overwrites the held item and never overflows.
// - A push whose size word differs from the frame size is rejected.
// - The kind field selects field meaning; only 0 and 1 are accepted, the LIN kinds 16, 17 and 18 are rejected.
// - Kind 0 sends a CAN data frame.
// - Kind 1 sends a CAN remote frame with no payload.
// - Identifier is 11-bit unless bit 29 is set, then 29-bit.
// - For data frames the byte count chooses how many of 8 bytes are sent.
// - Remote frames carry no bytes and the byte count becomes their DLC.
// - A frame is sent only when the controller reports arbitration and ack.
module ctxq_top #(
	parameter DEPTH_MAX = 8,
	parameter AW        = 3
) (
	input  wire        ref_clk_i,     // System clock
	input  wire        rst_n_i,       // Async reset, active low
	input  wire        psel_i,        // APB select
	input  wire        penable_i,     // APB enable
	input  wire        pwrite_i,      // APB write
	input  wire [7:0]  paddr_i,       // APB byte address
	input  wire [31:0] pwdata_i,      // APB write data
	output reg  [31:0] prdata_o,      // APB read data
	output reg         pready_o,      // APB ready
	output reg         pslverr_o,     // APB error
	output reg         tx_req_o,      // Frame request to controller
	output reg         tx_ext_o,      // Extended identifier
	output reg         tx_rtr_o,      // Remote frame
	output reg  [28:0] tx_id_o,       // Identifier
	output reg  [3:0]  tx_dlc_o,      // Data length code
	output reg  [63:0] tx_data_o,     // Payload, byte 0 in low bits
	input  wire        tx_done_i,     // Sent: arbitration won and acked
	input  wire        tx_fail_i,     // Attempt abandoned
	output reg         write_complete_state_o, // All pushed frames sent
	output reg         irq_o          // Level interrupt
);
	localparam ST_IDLE = 2'b01;
	localparam ST_BUSY = 2'b10;

	reg [1:0]  state_r;
	reg        start_r, per_r;
	reg [31:0] period_r, pcnt_r;
	reg [7:0]  depth_r;
	reg [31:0] size_r, id_r, dlo_r, dhi_r;
	reg [7:0]  kind_r, len_r;
	reg [3:0]  stat_r, mask_r;
	reg [AW:0] cnt_r;
	reg [AW-1:0] rd_r, wr_r;
	reg [7:0]  mem_kind [0:DEPTH_MAX-1];
	reg [31:0] mem_id   [0:DEPTH_MAX-1];
	reg [63:0] mem_dat  [0:DEPTH_MAX-1];
	reg [7:0]  mem_len  [0:DEPTH_MAX-1];
	reg        last_vld_r;
	reg        pop_was_last_r;
	reg        pending_r;

	wire acc   = psel_i & penable_i & pready_o;
	wire wr_en = acc & pwrite_i;
	wire push_req = wr_en & (paddr_i == `CTXQ_PUSH_OFS);
	wire size_ok  = (pwdata_i == size_r);
	wire kind_ok  = (kind_r == `CTXQ_KIND_DATA) |
			(kind_r == `CTXQ_KIND_REMOTE);
	wire zero_q   = (depth_r == 8'h00);
	wire [AW:0] lim = zero_q ? {{AW{1'b0}}, 1'b1} :
			(depth_r > DEPTH_MAX ? DEPTH_MAX[AW:0] : depth_r[AW:0]);
	wire full     = (cnt_r >= lim);
	wire empty    = (cnt_r == {(AW+1){1'b0}});
	wire push_ok  = push_req & size_ok & kind_ok & (~full | zero_q);
	wire overwr   = push_ok & zero_q & ~empty;
	wire tick     = per_r & (pcnt_r == 32'h0000_0000) &
			(period_r != 32'h0000_0000);
	wire idle     = (state_r == ST_IDLE);
	wire launch   = start_r & idle & (per_r ? tick & (~empty | last_vld_r)
			: ~empty);
	wire pop      = launch & ~empty;
	wire [AW-1:0] wsel = overwr ? rd_r : wr_r;
	wire [3:0]  ev;
	wire [31:0] dlen_clip = (len_r > 8'h08) ? 32'h0000_0008 :
			{24'h0000_00, len_r};

	assign ev[`CTXQ_EV_DONE_BIT] = (state_r == ST_BUSY) & tx_done_i &
			pop_was_last_r & empty & ~pending_r;
	assign ev[`CTXQ_EV_OVF_BIT]  = push_req & size_ok & kind_ok & full &
			~zero_q;
	assign ev[`CTXQ_EV_SIZE_BIT] = push_req & ~size_ok;
	assign ev[`CTXQ_EV_KIND_BIT] = push_req & size_ok & ~kind_ok;

	// Registers and APB writes
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			start_r  <= 1'b0;
			per_r    <= 1'b0;
			period_r <= `CTXQ_PERIOD_RST;
			depth_r  <= `CTXQ_DEPTH_RST;
			size_r   <= `CTXQ_FRAME_SIZE;
			kind_r   <= 8'h00;
			id_r     <= 32'h0000_0000;
			dlo_r    <= 32'h0000_0000;
			dhi_r    <= 32'h0000_0000;
			len_r    <= 8'h00;
			mask_r   <= 4'h0;
		end else if (wr_en) begin
			case (paddr_i)
			`CTXQ_CTRL_OFS: begin
				start_r <= pwdata_i[`CTXQ_CTRL_START_BIT];
				per_r   <= pwdata_i[`CTXQ_CTRL_PER_BIT];
			end
			`CTXQ_PERIOD_OFS: period_r <= pwdata_i;
			`CTXQ_DEPTH_OFS:  depth_r  <= pwdata_i[7:0];
			`CTXQ_SIZE_OFS:   size_r   <= pwdata_i;
			`CTXQ_KIND_OFS:   kind_r   <= pwdata_i[7:0];
			`CTXQ_ID_OFS:     id_r     <= pwdata_i;
			`CTXQ_DLO_OFS:    dlo_r    <= pwdata_i;
			`CTXQ_DHI_OFS:    dhi_r    <= pwdata_i;
			`CTXQ_LEN_OFS:    len_r    <= pwdata_i[7:0];
			`CTXQ_MASK_OFS:   mask_r   <= pwdata_i[3:0];
			default: ;
			endcase
		end
	end

	// Sticky status: set beats a same-cycle clear
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			stat_r <= 4'h0;
		else
			stat_r <= (stat_r & ~((wr_en && paddr_i == `CTXQ_IRQ_OFS) ?
				pwdata_i[3:0] : 4'h0)) | ev;
	end

	// Descriptor store, circular order
	always @(posedge ref_clk_i) begin
		if (push_ok) begin
			mem_kind[wsel] <= kind_r;
			mem_id[wsel]   <= id_r;
			mem_dat[wsel]  <= {dhi_r, dlo_r};
			mem_len[wsel]  <= len_r;
		end
	end

	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= {(AW+1){1'b0}};
			rd_r  <= {AW{1'b0}};
			wr_r  <= {AW{1'b0}};
		end else begin
			// Write pointer always leads read by the count, depth 0 too
			if (push_ok & ~overwr)
				wr_r <= (wr_r == DEPTH_MAX[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : wr_r + 1'b1;
			if (pop)
				rd_r <= (rd_r == DEPTH_MAX[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : rd_r + 1'b1;
			case ({push_ok & ~overwr, pop})
			2'b10: cnt_r <= cnt_r + 1'b1;
			2'b01: cnt_r <= cnt_r - 1'b1;
			default: ;
			endcase
		end
	end

	// Period counter
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			pcnt_r <= 32'h0000_0000;
		else if (!per_r || !start_r || pcnt_r == 32'h0000_0000)
			pcnt_r <= (period_r == 32'h0000_0000) ? 32'h0000_0000 :
				period_r - 32'h0000_0001;
		else
			pcnt_r <= pcnt_r - 32'h0000_0001;
	end

	// Transmit sequencer
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r   <= ST_IDLE;
			tx_req_o  <= 1'b0;
			tx_ext_o  <= 1'b0;
			tx_rtr_o  <= 1'b0;
			tx_id_o   <= 29'h0000_0000;
			tx_dlc_o  <= 4'h0;
			tx_data_o <= 64'h0000_0000_0000_0000;
			last_vld_r <= 1'b0;
			pop_was_last_r <= 1'b0;
		end else begin
			case (state_r)
			ST_IDLE: begin
				if (launch) begin
					state_r  <= ST_BUSY;
					tx_req_o <= 1'b1;
					pop_was_last_r <= pop;
					if (pop) begin
						last_vld_r <= 1'b1;
						tx_rtr_o <= (mem_kind[rd_r] ==
							`CTXQ_KIND_REMOTE);
						tx_ext_o <= mem_id[rd_r][`CTXQ_XTD_BIT];
						tx_id_o  <= mem_id[rd_r][`CTXQ_XTD_BIT] ?
							mem_id[rd_r][28:0] :
							{18'h0_0000, mem_id[rd_r][10:0]};
						tx_dlc_o <= mem_len[rd_r][3:0];
						tx_data_o <= (mem_kind[rd_r] ==
							`CTXQ_KIND_REMOTE) ? 64'h0 :
							mem_dat[rd_r];
					end
				end
			end
			ST_BUSY: begin
				if (tx_done_i | tx_fail_i) begin
					state_r  <= ST_IDLE;
					tx_req_o <= 1'b0;
				end
			end
			default: state_r <= ST_IDLE;
			endcase
			if (!start_r)
				last_vld_r <= 1'b0;
		end
	end

	// Push seen while a frame is in flight blocks completion
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			pending_r <= 1'b0;
		else
			pending_r <= push_ok ? ~launch : (launch ? 1'b0 : pending_r);
	end

	// Write-complete state
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			write_complete_state_o <= 1'b1;
		else if (push_ok)
			write_complete_state_o <= 1'b0;
		else if (wr_en && paddr_i == `CTXQ_CTRL_OFS &&
				pwdata_i[`CTXQ_CTRL_START_BIT] && !start_r && empty)
			write_complete_state_o <= 1'b1;
		else if (ev[`CTXQ_EV_DONE_BIT])
			write_complete_state_o <= 1'b1;
	end

	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(((stat_r & ~((wr_en && paddr_i == `CTXQ_IRQ_OFS)
				? pwdata_i[3:0] : 4'h0)) | ev) & mask_r);
	end

	// APB answer: zero wait, ready in the first access phase cycle
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end else begin
			pready_o  <= psel_i & ~penable_i;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			if (psel_i & ~penable_i) begin
				if (paddr_i > `CTXQ_LEVEL_OFS || paddr_i[1:0] != 2'b00)
					pslverr_o <= 1'b1;
				if (!pwrite_i) begin
					case (paddr_i)
					`CTXQ_CTRL_OFS:   prdata_o <= {30'h0, per_r, start_r};
					`CTXQ_PERIOD_OFS: prdata_o <= period_r;
					`CTXQ_DEPTH_OFS:  prdata_o <= {24'h0, depth_r};
					`CTXQ_SIZE_OFS:   prdata_o <= size_r;
					`CTXQ_KIND_OFS:   prdata_o <= {24'h0, kind_r};
					`CTXQ_ID_OFS:     prdata_o <= id_r;
					`CTXQ_DLO_OFS:    prdata_o <= dlo_r;
					`CTXQ_DHI_OFS:    prdata_o <= dhi_r;
					`CTXQ_LEN_OFS:    prdata_o <= dlen_clip;
					`CTXQ_STAT_OFS:   prdata_o <= {29'h0,
						~empty & ~full, full, write_complete_state_o};
					`CTXQ_IRQ_OFS:    prdata_o <= {28'h0, stat_r};
					`CTXQ_MASK_OFS:   prdata_o <= {28'h0, mask_r};
					`CTXQ_LEVEL_OFS:  prdata_o <= {{(31-AW){1'b0}}, cnt_r};
					default:          prdata_o <= 32'h0000_0000;
					endcase
				end
			end
		end
	end
endmodule // ctxq_top

//--- testbench/ctxq_sva.sv
// Purpose: Port assertions for the CAN transmit write queue.
// Assumes: One clock, async active-low reset.
// Notes:   Bound into ctxq_top below.
module ctxq_sva (
	input logic        ref_clk_i,              // Clock
	input logic        rst_n_i,                // Reset
	input logic        psel_i,                 // Select
	input logic        penable_i,              // Enable
	input logic        pwrite_i,               // Write
	input logic        pready_o,               // Ready
	input logic        tx_req_o,               // Request
	input logic        tx_ext_o,               // Extended
	input logic        tx_rtr_o,               // Remote
	input logic [28:0] tx_id_o,                // Identifier
	input logic [3:0]  tx_dlc_o,               // Length code
	input logic [63:0] tx_data_o,              // Payload
	input logic        tx_done_i,              // Sent
	input logic        write_complete_state_o  // All sent
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_setup;
		psel_i && !penable_i;
	endsequence
	sequence s_busy;
		tx_req_o && !tx_done_i;
	endsequence
	a_push_fast: assert property (s_setup |=> pready_o)
		else $error("access not answered at once");
	a_wc_rise: assert property ($rose(write_complete_state_o) |->
		$past(tx_done_i) || $past(psel_i && pwrite_i))
		else $error("write complete rose without a send");
	a_wc_hold: assert property (write_complete_state_o && !psel_i
		|=> write_complete_state_o)
		else $error("write complete dropped without a push");
	a_req_hold: assert property (s_busy |=> tx_req_o && $stable(tx_id_o)
		&& $stable(tx_dlc_o) && $stable(tx_data_o))
		else $error("frame changed before done");
	a_req_end: assert property (tx_req_o && tx_done_i |=> !tx_req_o)
		else $error("request held after done");
	a_rtr_empty: assert property (tx_req_o && tx_rtr_o |->
		tx_data_o == 64'h0)
		else $error("remote frame carries payload");
	a_std_id: assert property (tx_req_o && !tx_ext_o |->
		tx_id_o[28:11] == 18'h0)
		else $error("standard id wider than 11 bits");
	a_dlc_max: assert property (tx_req_o && !tx_rtr_o |->
		tx_dlc_o <= 4'h8)
		else $error("data length above 8");
endmodule // ctxq_sva

bind ctxq_top ctxq_sva u_sva (.*);

//--- testbench/ctxq_can_node.sv
// Purpose: Remote CAN side: takes each offered frame and acknowledges it.
// Assumes: Fixed latency from lat_i; never abandons a frame.
// Notes:   Logs sent frames as {ext, rtr, dlc, id, data}.
module ctxq_can_node (
	input  wire logic        ref_clk_i, // Clock
	input  wire logic        rst_n_i,   // Reset
	input  wire logic        req_i,     // Frame offered
	input  wire logic        ext_i,     // Extended
	input  wire logic        rtr_i,     // Remote
	input  wire logic [28:0] id_i,      // Identifier
	input  wire logic [3:0]  dlc_i,     // Length code
	input  wire logic [63:0] data_i,    // Payload
	input  wire logic [7:0]  lat_i,     // Cycles to ack
	output logic             done_o     // Won and acked
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [98:0] log_q[$];
	logic [7:0]  cnt_r;
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= 8'h00;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			// Skip the done cycle: request falls one edge later
			if (req_i && !done_o) begin
				if (cnt_r == lat_i) begin
					cnt_r <= 8'h00;
					done_o <= 1'b1;
					log_q.push_back({ext_i, rtr_i, dlc_i, id_i, data_i});
				end else begin
					cnt_r <= cnt_r + 8'h01;
				end
			end
		end
	end
endmodule // ctxq_can_node

//--- testbench/test_can_tx_write_queue.sv
// Purpose: Self-checking bench of the CAN transmit write queue.
// Assumes: APB master here, remote node model on the frame side.
// Notes:   Frame abandon input held low.
module test_can_tx_write_queue;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, psel, pen, pwr, pready, req, ext, rtr, done, wc;
	logic        irq, perr, e;
	logic [7:0]  paddr, lat;
	logic [31:0] pwdata, prdata, q;
	logic [28:0] id;
	logic [3:0]  dlc;
	logic [63:0] data;
	int          failures, n_tests, k;
	ctxq_top dut (.ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .tx_req_o(req),
		.tx_ext_o(ext), .tx_rtr_o(rtr), .tx_id_o(id), .tx_dlc_o(dlc),
		.tx_data_o(data), .tx_done_i(done), .tx_fail_i(1'b0),
		.write_complete_state_o(wc), .irq_o(irq));
	ctxq_can_node u_node (.ref_clk_i(clk), .rst_n_i(rst_n), .req_i(req),
		.ext_i(ext), .rtr_i(rtr), .id_i(id), .dlc_i(dlc), .data_i(data),
		.lat_i(lat), .done_o(done));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task wrap_up;
		$display("failures=%0d n_tests=%0d", failures, n_tests);
		if (failures == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input bit ok, input string m);
		n_tests++;
		if (!ok) begin
			failures++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task apb(input bit w, input [7:0] a, input [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Sample settled answer, release after the edge that takes it
		@(negedge clk);
		while (pready !== 1'b1) @(negedge clk);
		q = prdata;
		e = perr;
		@(posedge clk);
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task push(input [31:0] kd, input [31:0] i, input [31:0] n);
		apb(1, 8'h10, kd);
		apb(1, 8'h14, i);
		apb(1, 8'h18, 32'h4433_2211);
		apb(1, 8'h1C, 32'h8877_6655);
		apb(1, 8'h20, n);
		apb(1, 8'h24, 32'h0000_0018);
	endtask
	task wait_wc;
		for (k = 0; k < 3000 && wc !== 1'b1; k++) @(posedge clk);
	endtask
	task t_start;
		apb(0, 8'h28, 32'h0);
		chk(q[0] === 1'b1 && wc === 1'b1, "wc not set at start");
		apb(0, 8'h38, 32'h0);
		chk(e === 1'b1, "bad address not refused");
		apb(1, 8'h00, 32'h1);
		@(negedge clk);
		chk(wc === 1'b1, "wc lost on start");
	endtask
	task t_fifo;
		lat <= 8'd40;
		push(0, 32'h0000_0123, 8);
		@(negedge clk);
		chk(wc === 1'b0 && done !== 1'b1, "push waited or kept wc");
		push(1, 32'h2000_0456, 3);
		wait_wc;
		chk(u_node.log_q.size() == 2, "frame count");
		chk(u_node.log_q[0] === {6'h08, 29'h123, 64'h8877_6655_4433_2211},
			"data frame");
		chk(u_node.log_q[1] === {6'h33, 29'h456, 64'h0}, "remote frame");
		u_node.log_q.delete();
	endtask
	task t_errs;
		lat <= 8'd2;
		apb(1, 8'h00, 32'h0);
		apb(1, 8'h08, 32'h2);
		apb(1, 8'h2C, 32'hF);
		apb(1, 8'h30, 32'h0);
		for (int i = 1; i < 4; i++) push(0, i, 1);
		apb(1, 8'h24, 32'h0000_0010);
		for (int c = 16; c < 19; c++) begin
			apb(1, 8'h10, c);
			apb(1, 8'h24, 32'h0000_0018);
		end
		apb(0, 8'h34, 32'h0);
		chk(q === 32'h2, "refused item stored");
		apb(0, 8'h2C, 32'h0);
		chk(q[3:1] === 3'b111 && irq === 1'b0, "error events");
		apb(1, 8'h30, 32'h2);
		repeat (2) @(negedge clk);
		chk(irq === 1'b1, "unmasked irq low");
		apb(1, 8'h2C, 32'hF);
		@(negedge clk);
		chk(irq === 1'b0, "irq not cleared");
		apb(1, 8'h00, 32'h1);
		wait_wc;
		chk(u_node.log_q[1][92:64] === 29'h2, "drain order");
		apb(1, 8'h00, 32'h0);
		apb(1, 8'h08, 32'h0);
		push(0, 5, 1);
		push(0, 6, 1);
		apb(0, 8'h2C, 32'h0);
		chk(q[1] === 1'b0 && irq === 1'b0, "overflow at depth 0");
		u_node.log_q.delete();
		apb(1, 8'h00, 32'h1);
		wait_wc;
		chk(u_node.log_q.size() == 1 && u_node.log_q[0][92:64] === 29'h6,
			"overwrite lost");
	endtask
	task t_period;
		apb(1, 8'h00, 32'h0);
		apb(1, 8'h08, 32'h8);
		apb(1, 8'h04, 32'd50);
		push(0, 7, 2);
		u_node.log_q.delete();
		apb(1, 8'h00, 32'h3);
		repeat (220) @(posedge clk);
		k = u_node.log_q.size();
		chk(k >= 4 && k <= 5, "one frame per period");
		chk(u_node.log_q[k-1] === u_node.log_q[0], "resend differs");
		push(0, 8, 2);
		repeat (120) @(posedge clk);
		chk(u_node.log_q[$][92:64] === 29'h8, "new item not sent");
		apb(1, 8'h00, 32'h0);
	endtask
	initial begin
		#100us;
		failures++;
		wrap_up;
	end
	initial begin
		{psel, pen, pwr, rst_n, paddr, pwdata, lat} = '0;
		failures = 0;
		n_tests = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_start;
		t_fifo;
		t_errs;
		t_period;
		wrap_up;
	end
endmodule // test_can_tx_write_queue
